// file: dv/codec_model.sv
// Behavioural codec on the serial side of the block.
// Assumes one task at a time; the bit clock stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  // Pins towards the block
  output logic bit_clk_o,
  output logic sync_o,
  output logic data_o,
  input wire logic tx_data_i,
  // Transmit bits seen, newest in bit 0
  output logic [31:0] cap_o
);
  initial
  begin
    bit_clk_o = 1'b0;
    sync_o = 1'b0;
    data_o = 1'b0;
    cap_o = 32'h0;
  end
  // Offset keeps bit edges clear of the block clock edge
  task automatic frame(input int n, input logic [31:0] d, input logic act);
    #1.3 sync_o = ~act;
    #80 bit_clk_o = 1'b1;
    sync_o = act;
    #80 bit_clk_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #80 bit_clk_o = 1'b1;
      sync_o = ~act;
      data_o = d[i];
      #80 bit_clk_o = 1'b0;
      cap_o = {cap_o[30:0], tx_data_i};
    end
    clocks(1);
  endtask
  // No pull on the data line, so it toggles once released
  task automatic clocks(input int n);
    #1.3;
    repeat (n)
    begin
      #80 bit_clk_o = 1'b1;
      data_o = ~data_o;
      #80 bit_clk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/frame_format_asserts.sv
// Port-level checks on the frame-format block.
// Assumes the bind below and classic single Wishbone cycles.
`timescale 1ns/1ps
`default_nettype none
module frame_format_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and interrupt
  input wire logic bit_clk_i,
  input wire logic tx_sync_pin_o,
  input wire logic tx_sync_pin_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic act;
  logic pol_reg;
  logic bclk_reg;
  logic [7:0] len_reg;
  logic [3:0] rises_reg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign act = tx_sync_pin_oe_o && (tx_sync_pin_o != pol_reg);
  // Raw pin edges: the block sees them late, so one falls inside each pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pol_reg <= 1'b0;
    else if (take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
      pol_reg <= wb_dat_i[4];
    bclk_reg <= bit_clk_i;
    len_reg <= act ? len_reg + 8'h01 : 8'h00;
    rises_reg <= !act ? 4'h0 : rises_reg + {3'h0, bit_clk_i && !bclk_reg};
  end
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (take |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i[7:5] != 3'h0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_fmt_spare_zero: assert property (
    take && !wb_we_i && wb_adr_i inside {8'h04, 8'h08} |=> (wb_dat_o & 32'h7880f880) == 32'h0)
    else $error("format spare bits not zero");
  chk_irq_mask_off: assert property (
    take && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[0] && wb_dat_i[1:0] == 2'h0 |-> ##2 !irq_o)
    else $error("irq high with all masked");
  chk_sync_pin_dir: assert property (
    take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] |-> ##2 tx_sync_pin_oe_o == $past(wb_dat_i[2], 2))
    else $error("sync pin direction wrong");
  chk_sync_width: assert property ($fell(act) && len_reg > 8'h08 |-> rises_reg == 4'h1)
    else $error("sync pulse not one bit clock");
endmodule
bind serial_frame_format_control frame_format_asserts chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .bit_clk_i, .tx_sync_pin_o, .tx_sync_pin_oe_o, .irq_o
);
`default_nettype wire

// file: dv/tb_serial_frame_format_control.sv
// Self-checking bench for the frame-format block.
// Assumes the codec model file and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_frame_format_control;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, cap;
  logic generator_frame_pulse_i, generator_frame_reset_n_i, bit_clk_i, sync, rx_data_pin_i;
  logic tx_sync_pin_o, tx_sync_pin_oe_o, tx_data_pin_o, tx_data_pin_oe_o, seen, act_hi;
  int len, fail_count, n_tests;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  wire logic rx_sync_pin_i;
  wire logic tx_sync_pin_i;
  assign rx_sync_pin_i = sync;
  assign tx_sync_pin_i = tx_sync_pin_oe_o ? tx_sync_pin_o : sync;
  serial_frame_format_control dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .generator_frame_pulse_i, .generator_frame_reset_n_i,
    .bit_clk_i, .rx_sync_pin_i, .rx_data_pin_i, .tx_sync_pin_i, .tx_sync_pin_o, .tx_sync_pin_oe_o,
    .tx_data_pin_o, .tx_data_pin_oe_o, .irq_o);
  codec_model codec_u (.bit_clk_o(bit_clk_i), .sync_o(sync), .data_o(rx_data_pin_i),
    .tx_data_i(tx_data_pin_o), .cap_o(cap));
  always #2 clk_i = ~clk_i;
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reads are judged by the monitor below when ack arrives
  always @(posedge clk_i)
    if (wb_ack_o && !wb_we_i && q_exp.size() > 0)
      check(wb_dat_o & q_msk.pop_front(), q_exp.pop_front(), "read");
  always @(posedge clk_i)
    if (tx_sync_pin_oe_o && tx_sync_pin_o === act_hi)
    begin
      seen <= 1'b1;
      len <= len + 1;
    end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (!wb_ack_o && k < 50);
    if (wb_ack_o !== 1'b1)
    begin
      check(32'h0, 32'h1, "bus timeout");
      stop_test();
    end
    else
    begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  // Pulse the generator with its frame logic held or released
  task automatic gen_try(input logic en);
    @(posedge clk_i);
    seen <= 1'b0;
    len <= 0;
    generator_frame_reset_n_i <= en;
    generator_frame_pulse_i <= 1'b1;
    @(posedge clk_i);
    generator_frame_pulse_i <= 1'b0;
    codec_u.clocks(14);
  endtask
  initial
  begin
    logic [31:0] d, r, f, m;
    logic [1:0] md;
    logic pol;
    int wid[6] = '{8, 12, 16, 20, 24, 32};
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, generator_frame_pulse_i, generator_frame_reset_n_i} = 5'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    {seen, act_hi, len, fail_count, n_tests} = '0;
    d = $urandom(32'hdc9a);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check(32'(irq_o), 32'h0, "irq in reset");
    rd(8'h00, 32'h0, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    wb(1'b1, 8'h10, 32'h3);
    for (int i = 0; i < 6; i++)
    begin
      pol = i[0];
      md = (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0;
      m = 32'((64'h1 << wid[i]) - 64'h1);
      d = $urandom;
      r = $urandom;
      f = ($urandom & 32'h077f0000) | (32'(i) << 8);
      wb(1'b1, 8'h0c, 32'h3);
      @(posedge clk_i);
      check(32'(irq_o), 32'h0, "irq after clear");
      wb(1'b1, 8'h00, {20'h0, md, md, 2'h0, pol, pol, 4'h3});
      wb(1'b1, 8'h04, f);
      wb(1'b1, 8'h08, f);
      wb(1'b1, 8'h14, d);
      rd(8'h08, f, 32'hffffffff);
      rd(8'h1c, 32'h00040012, 32'h07fc1ff3);
      codec_u.frame(wid[i], r, ~pol);
      rd(8'h18, r & m, 32'hffffffff);
      check(cap & m, d & m, "tx bits");
      rd(8'h0c, {30'h0, {2{md != 2'h1}}}, 32'h3);
      check(32'(irq_o), 32'(md != 2'h1), "irq level");
    end
    // Dual frames stay far below the generated-sync bit limit
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h04, ($urandom & 32'h077f0000) | 32'h300);
    wb(1'b1, 8'h08, 32'h80000100);
    wb(1'b1, 8'h14, d);
    rd(8'h1c, 32'h00080010, 32'h07fc1ff0);
    codec_u.frame(20, r, 1'b1);
    rd(8'h18, r & 32'hfffff, 32'hffffffff);
    check(cap & 32'hfffff, {12'h0, d[11:0], d[7:0]}, "dual bits");
    wb(1'b1, 8'h04, 32'h807f007f);
    wb(1'b1, 8'h08, 32'h0000007f);
    rd(8'h1c, 32'h02001000, 32'h07fc1ff0);
    act_hi <= 1'b0;
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h0c, 32'h3);
    wb(1'b1, 8'h00, 32'h81e);
    gen_try(1'b0);
    check(32'(seen), 32'h0, "sync while held");
    gen_try(1'b1);
    check(32'(seen), 32'h1, "generator sync");
    check(32'(len >= 38 && len <= 42), 32'h1, "generator width");
    rd(8'h0c, 32'h2, 32'h2);
    act_hi <= 1'b1;
    wb(1'b1, 8'h00, 32'h806);
    wb(1'b1, 8'h0c, 32'h3);
    wb(1'b1, 8'h14, d);
    gen_try(1'b0);
    check(32'(seen), 32'h1, "copy sync");
    check(32'(len >= 38 && len <= 42), 32'h1, "copy width");
    rd(8'h0c, 32'h2, 32'h2);
    wb(1'b1, 8'h10, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// file: src/frame_format_consts.svh
// Offsets, field positions, interrupt modes and pin slots for the frame-format block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FRAME_FORMAT_CONSTS_SVH
`define FRAME_FORMAT_CONSTS_SVH

// Register word indices on the bus, taken from byte address bits 4:2
`define OFS_CTRL 3'h0
`define OFS_RX_FMT 3'h1
`define OFS_TX_FMT 3'h2
`define OFS_STATUS 3'h3
`define OFS_MASK 3'h4
`define OFS_TX_DATA 3'h5
`define OFS_RX_DATA 3'h6
`define OFS_STATE 3'h7
`define ADR_WIDTH 8
`define ADR_MAPPED_TOP 3'h0

// Control register fields
`define CTRL_RX_EN 0
`define CTRL_TX_EN 1
`define CTRL_SRC_SEL 2
`define CTRL_GEN_MODE 3
`define CTRL_TX_POL 4
`define CTRL_RX_POL 5
`define CTRL_RX_IRQ_LO 8
`define CTRL_TX_IRQ_LO 10

// Format register fields
`define FMT_P1_COUNT_LO 0
`define FMT_P1_WIDTH_LO 8
`define FMT_P2_COUNT_LO 16
`define FMT_P2_WIDTH_LO 24
`define FMT_PHASE 31

// Status and mask bits
`define ST_RX 0
`define ST_TX 1

// Interrupt modes
`define IRQ_MODE_ELEMENT 2'h0
`define IRQ_MODE_FRAME 2'h2

// Pin synchroniser slots
`define PIN_CLK 0
`define PIN_RXS 1
`define PIN_TXS 2
`define PIN_RXD 3
`define PIN_COUNT 4

`endif

// file: src/frame_format_pkg.sv
// Types and decode helpers shared by the frame-format block.
// Assumes the constants header sits beside it.
package frame_format_pkg;
  `include "frame_format_consts.svh"

  typedef struct packed {
    logic dual_phase;
    logic [6:0] p1_count;
    logic [2:0] p1_width;
    logic [6:0] p2_count;
    logic [2:0] p2_width;
  } fmt_t;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic src_sel;
    logic gen_mode;
    logic tx_pol;
    logic rx_pol;
    logic [1:0] rx_irq_mode;
    logic [1:0] tx_irq_mode;
  } ctrl_t;

  typedef enum logic [1:0] {seq_idle, seq_phase_one, seq_phase_two} seq_phase_t;

  typedef struct packed {
    seq_phase_t phase;
    logic [6:0] elem;
    logic [5:0] bit_idx;
  } seq_state_t;

  // Element width in bits; reserved codes fall back to the widest
  function automatic logic [5:0] width_bits(input logic [2:0] code);
    case (code)
      3'h0: width_bits = 6'h08;
      3'h1: width_bits = 6'h0c;
      3'h2: width_bits = 6'h10;
      3'h3: width_bits = 6'h14;
      3'h4: width_bits = 6'h18;
      default: width_bits = 6'h20;
    endcase
  endfunction

  // Time slots per frame
  function automatic logic [8:0] frame_slots(input fmt_t f);
    frame_slots = {2'h0, f.p1_count} + 9'h001;
    if (f.dual_phase)
      frame_slots = frame_slots + {2'h0, f.p2_count} + 9'h001;
  endfunction

  function automatic fmt_t fmt_from_word(input logic [31:0] w);
    fmt_from_word.dual_phase = w[`FMT_PHASE];
    fmt_from_word.p1_count = w[`FMT_P1_COUNT_LO +: 7];
    fmt_from_word.p1_width = w[`FMT_P1_WIDTH_LO +: 3];
    fmt_from_word.p2_count = w[`FMT_P2_COUNT_LO +: 7];
    fmt_from_word.p2_width = w[`FMT_P2_WIDTH_LO +: 3];
  endfunction

  function automatic logic [31:0] fmt_to_word(input fmt_t f);
    fmt_to_word = 32'h0;
    fmt_to_word[`FMT_PHASE] = f.dual_phase;
    fmt_to_word[`FMT_P1_COUNT_LO +: 7] = f.p1_count;
    fmt_to_word[`FMT_P1_WIDTH_LO +: 3] = f.p1_width;
    fmt_to_word[`FMT_P2_COUNT_LO +: 7] = f.p2_count;
    fmt_to_word[`FMT_P2_WIDTH_LO +: 3] = f.p2_width;
  endfunction
endpackage

// file: src/frame_sequencer.sv
// Counts bits, elements and phases of one frame direction.
// Assumes tick_i is a one-cycle sample enable and sync_i an internal level.
`timescale 1ns/1ps
`default_nettype none
module frame_sequencer
  import frame_format_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic sync_i,
  input wire fmt_t fmt_i,
  // Progress
  output logic busy_o,
  output logic [5:0] width_o,
  output logic frame_start_o,
  output logic elem_done_o,
  output logic frame_done_o
);
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [6:0] last_elem;
  logic last_bit;

  assign busy_o = state_reg.phase != seq_idle;

  always_comb
  begin
    state_next = state_reg;
    frame_start_o = 1'b0;
    elem_done_o = 1'b0;
    frame_done_o = 1'b0;
    // Phase-2 fields only matter in the second phase
    width_o = width_bits(state_reg.phase == seq_phase_two ? fmt_i.p2_width : fmt_i.p1_width);
    last_elem = state_reg.phase == seq_phase_two ? fmt_i.p2_count : fmt_i.p1_count;
    last_bit = state_reg.bit_idx == width_o - 6'h01;
    if (!enable_i)
    begin
      state_next = '{seq_idle, 7'h00, 6'h00};
    end
    else if (tick_i)
    begin
      case (state_reg.phase)
        seq_idle:
          // Nothing moves without a sync; later syncs mid-frame are ignored
          if (sync_i)
          begin
            state_next = '{seq_phase_one, 7'h00, 6'h00};
            frame_start_o = 1'b1;
          end
        seq_phase_one, seq_phase_two:
          if (last_bit)
          begin
            elem_done_o = 1'b1;
            state_next.bit_idx = 6'h00;
            if (state_reg.elem != last_elem)
              state_next.elem = state_reg.elem + 7'h01;
            else if (state_reg.phase == seq_phase_one && fmt_i.dual_phase)
            begin
              state_next.phase = seq_phase_two;
              state_next.elem = 7'h00;
            end
            else
            begin
              state_next.phase = seq_idle;
              frame_done_o = 1'b1;
            end
          end
          else
            state_next.bit_idx = state_reg.bit_idx + 6'h01;
        default:
          state_next.phase = seq_idle;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= '{seq_idle, 7'h00, 6'h00};
    else
      state_reg <= state_next;
  end
endmodule
`default_nettype wire

// file: src/serial_frame_format_control.sv
// Frame-format and transmit frame-sync selection of a buffered serial port.
// Assumes a classic Wishbone master on clk_i and serial pins from another domain.
//
// How it works
// - Source 0: sync from pin, polarity applied
// - Source 1, generator mode: generator pulse drives sync
// - Source 1, copy mode: each copy pulses sync
// - Interrupt mode 10b fires on frame sync
// - Transfers start only after a valid sync
// - Phase bit picks single or dual frames
// - Separate counts and widths per phase, direction
// - Bits run contiguous across elements and phases
// - Count field holds elements minus one
// - Up to 128 or 256 elements per frame
// - Width codes decode to 8 through 32
// - Single phase ignores phase-2 fields
// - Frame length sets the slots per frame
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_format_control
  import frame_format_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sample-rate generator
  input wire logic generator_frame_pulse_i,
  input wire logic generator_frame_reset_n_i,
  // Serial pins
  input wire logic bit_clk_i,
  input wire logic rx_sync_pin_i,
  input wire logic rx_data_pin_i,
  input wire logic tx_sync_pin_i,
  output logic tx_sync_pin_o,
  output logic tx_sync_pin_oe_o,
  output logic tx_data_pin_o,
  output logic tx_data_pin_oe_o,
  // Interrupt
  output logic irq_o
);
  typedef struct packed {
    ctrl_t ctrl;
    fmt_t rx_fmt;
    fmt_t tx_fmt;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] tx_data;
    logic [31:0] tx_shift;
    logic [31:0] rx_shift;
    logic [31:0] rx_data;
    logic tx_full;
    logic rx_full;
    logic gen_pending;
    logic copy_seen;
    logic tx_sync_int;
    logic tx_bit;
    logic ack;
    logic [31:0] rd_data;
    logic [`PIN_COUNT-1:0] pin_meta;
    logic [`PIN_COUNT-1:0] pin_sync;
    logic clk_prev;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        merge[i*8 +: 8] = val[i*8 +: 8];
  endfunction

  function automatic logic [31:0] ctrl_to_word(input ctrl_t c);
    ctrl_to_word = 32'h0;
    ctrl_to_word[`CTRL_RX_EN] = c.rx_en;
    ctrl_to_word[`CTRL_TX_EN] = c.tx_en;
    ctrl_to_word[`CTRL_SRC_SEL] = c.src_sel;
    ctrl_to_word[`CTRL_GEN_MODE] = c.gen_mode;
    ctrl_to_word[`CTRL_TX_POL] = c.tx_pol;
    ctrl_to_word[`CTRL_RX_POL] = c.rx_pol;
    ctrl_to_word[`CTRL_RX_IRQ_LO +: 2] = c.rx_irq_mode;
    ctrl_to_word[`CTRL_TX_IRQ_LO +: 2] = c.tx_irq_mode;
  endfunction

  function automatic ctrl_t ctrl_from_word(input logic [31:0] w);
    ctrl_from_word.rx_en = w[`CTRL_RX_EN];
    ctrl_from_word.tx_en = w[`CTRL_TX_EN];
    ctrl_from_word.src_sel = w[`CTRL_SRC_SEL];
    ctrl_from_word.gen_mode = w[`CTRL_GEN_MODE];
    ctrl_from_word.tx_pol = w[`CTRL_TX_POL];
    ctrl_from_word.rx_pol = w[`CTRL_RX_POL];
    ctrl_from_word.rx_irq_mode = w[`CTRL_RX_IRQ_LO +: 2];
    ctrl_from_word.tx_irq_mode = w[`CTRL_TX_IRQ_LO +: 2];
  endfunction

  logic bit_rise;
  logic bit_fall;
  logic copy_mode;
  logic tx_sync_internal;
  logic rx_sync_internal;
  logic rx_busy;
  logic rx_start;
  logic rx_elem_done;
  logic rx_frame_done;
  logic [5:0] rx_width;
  logic tx_busy;
  logic tx_start;
  logic tx_elem_done;
  logic tx_frame_done;
  logic [5:0] tx_width;
  logic tx_load;
  logic idle_copy;
  logic bus_req;
  logic bus_wr;
  logic mapped;
  logic [2:0] reg_idx;
  logic [31:0] rx_word;
  logic [1:0] status_set;
  logic [1:0] status_clr;

  assign bit_rise = state_reg.pin_sync[`PIN_CLK] && !state_reg.clk_prev;
  assign bit_fall = !state_reg.pin_sync[`PIN_CLK] && state_reg.clk_prev;
  assign copy_mode = state_reg.ctrl.src_sel && !state_reg.ctrl.gen_mode;
  assign rx_sync_internal = state_reg.pin_sync[`PIN_RXS] ^ state_reg.ctrl.rx_pol;
  // Pin input in mode 0, otherwise the registered internal pulse
  assign tx_sync_internal = state_reg.ctrl.src_sel ? state_reg.tx_sync_int
                          : state_reg.pin_sync[`PIN_TXS] ^ state_reg.ctrl.tx_pol;

  // Both directions sample sync on the falling bit-clock edge, and receive data is sampled there too
  frame_sequencer rx_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(state_reg.ctrl.rx_en),
    .tick_i(bit_fall),
    .sync_i(rx_sync_internal),
    .fmt_i(state_reg.rx_fmt),
    .busy_o(rx_busy),
    .width_o(rx_width),
    .frame_start_o(rx_start),
    .elem_done_o(rx_elem_done),
    .frame_done_o(rx_frame_done)
  );

  frame_sequencer tx_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(state_reg.ctrl.tx_en),
    .tick_i(bit_fall),
    .sync_i(tx_sync_internal),
    .fmt_i(state_reg.tx_fmt),
    .busy_o(tx_busy),
    .width_o(tx_width),
    .frame_start_o(tx_start),
    .elem_done_o(tx_elem_done),
    .frame_done_o(tx_frame_done)
  );

  assign bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign bus_wr = bus_req && wb_we_i;
  assign mapped = wb_adr_i[`ADR_WIDTH-1:5] == `ADR_MAPPED_TOP;
  assign reg_idx = wb_adr_i[4:2];
  // Copy mode has no sync until a word is copied, so the idle copy starts it
  assign idle_copy = copy_mode && state_reg.ctrl.tx_en && !tx_busy && state_reg.tx_full
                   && bit_rise && !state_reg.copy_seen && !state_reg.tx_sync_int;
  // In copy mode the first element was already loaded by the idle copy
  assign tx_load = (tx_start && !copy_mode) || (tx_elem_done && !tx_frame_done);
  assign rx_word = {state_reg.rx_shift[30:0], state_reg.pin_sync[`PIN_RXD]};

  always_comb
  begin
    state_next = state_reg;
    status_set = 2'h0;
    status_clr = 2'h0;

    // Two-flop capture of every pin from the bit-clock domain
    state_next.pin_meta = {tx_sync_pin_i, rx_data_pin_i, rx_sync_pin_i, bit_clk_i};
    state_next.pin_meta = {state_next.pin_meta[`PIN_TXS], state_next.pin_meta[`PIN_RXD],
                           state_next.pin_meta[`PIN_RXS], state_next.pin_meta[`PIN_CLK]};
    state_next.pin_meta[`PIN_RXD] = rx_data_pin_i;
    state_next.pin_meta[`PIN_TXS] = tx_sync_pin_i;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.clk_prev = state_reg.pin_sync[`PIN_CLK];

    // Receive: shift in after the sync bit, hand each element to software
    if (rx_busy && bit_fall && !rx_start)
      state_next.rx_shift = rx_word;
    if (rx_elem_done)
    begin
      state_next.rx_data = rx_word;
      state_next.rx_shift = 32'h0;
      state_next.rx_full = 1'b1;
      if (state_reg.ctrl.rx_irq_mode == `IRQ_MODE_ELEMENT)
        status_set[`ST_RX] = 1'b1;
    end
    if (rx_start && state_reg.ctrl.rx_irq_mode == `IRQ_MODE_FRAME)
      status_set[`ST_RX] = 1'b1;

    // Generator pulse is short; hold it until the next rising bit edge
    if (state_reg.ctrl.src_sel && state_reg.ctrl.gen_mode && generator_frame_pulse_i
        && generator_frame_reset_n_i)
      state_next.gen_pending = 1'b1;
    else if (bit_rise)
      state_next.gen_pending = 1'b0;

    // Internal transmit sync lasts one whole bit clock in the output modes
    if (bit_rise)
    begin
      if (!state_reg.ctrl.src_sel)
        state_next.tx_sync_int = 1'b0;
      else if (state_reg.ctrl.gen_mode)
        state_next.tx_sync_int = state_reg.gen_pending;
      else
        state_next.tx_sync_int = state_reg.copy_seen;
      state_next.copy_seen = 1'b0;
    end

    // Transmit: copy data register into the shift register
    if (tx_load || idle_copy)
    begin
      state_next.tx_shift = state_reg.tx_data;
      state_next.tx_full = 1'b0;
      if (copy_mode)
        state_next.copy_seen = 1'b1;
      if (state_reg.ctrl.tx_irq_mode == `IRQ_MODE_ELEMENT)
        status_set[`ST_TX] = 1'b1;
    end
    if (tx_start && state_reg.ctrl.tx_irq_mode == `IRQ_MODE_FRAME)
      status_set[`ST_TX] = 1'b1;
    // Data changes on the rising edge, MSB of the current element first
    if (tx_busy && bit_rise)
    begin
      state_next.tx_bit = state_reg.tx_shift[5'(tx_width - 6'h01)];
      state_next.tx_shift = {state_reg.tx_shift[30:0], 1'b0};
    end

    // Bus slave: one wait state, ack is a single-cycle pulse
    state_next.ack = bus_req;
    if (bus_req)
    begin
      state_next.rd_data = 32'h0;
      if (mapped && !wb_we_i)
        case (reg_idx)
          `OFS_CTRL: state_next.rd_data = ctrl_to_word(state_reg.ctrl);
          `OFS_RX_FMT: state_next.rd_data = fmt_to_word(state_reg.rx_fmt);
          `OFS_TX_FMT: state_next.rd_data = fmt_to_word(state_reg.tx_fmt);
          `OFS_STATUS: state_next.rd_data = {30'h0, state_reg.status};
          `OFS_MASK: state_next.rd_data = {30'h0, state_reg.mask};
          `OFS_TX_DATA: state_next.rd_data = state_reg.tx_data;
          `OFS_RX_DATA: state_next.rd_data = state_reg.rx_data;
          `OFS_STATE: state_next.rd_data = {5'h0, frame_slots(state_reg.tx_fmt), 5'h0,
                                            frame_slots(state_reg.rx_fmt),
                                            tx_busy, rx_busy, state_reg.tx_full, state_reg.rx_full};
          default: state_next.rd_data = 32'h0;
        endcase
      // Reading received data frees the register unless a new element lands now
      if (mapped && !wb_we_i && reg_idx == `OFS_RX_DATA && !rx_elem_done)
        state_next.rx_full = 1'b0;
    end

    if (bus_wr && mapped)
      case (reg_idx)
        `OFS_CTRL: state_next.ctrl = ctrl_from_word(merge(ctrl_to_word(state_reg.ctrl), wb_dat_i, wb_sel_i));
        `OFS_RX_FMT: state_next.rx_fmt = fmt_from_word(merge(fmt_to_word(state_reg.rx_fmt), wb_dat_i,
                                                              wb_sel_i));
        `OFS_TX_FMT: state_next.tx_fmt = fmt_from_word(merge(fmt_to_word(state_reg.tx_fmt), wb_dat_i,
                                                              wb_sel_i));
        `OFS_STATUS:
          if (wb_sel_i[0])
            status_clr = wb_dat_i[1:0];
        `OFS_MASK:
          if (wb_sel_i[0])
            state_next.mask = wb_dat_i[1:0];
        `OFS_TX_DATA:
        begin
          // A write landing with a copy still counts as a fresh word
          state_next.tx_data = merge(state_reg.tx_data, wb_dat_i, wb_sel_i);
          state_next.tx_full = 1'b1;
        end
        default:
          state_next.tx_full = state_next.tx_full;
      endcase

    // Hardware set wins over a same-cycle software clear
    state_next.status = (state_reg.status & ~status_clr) | status_set;

    // A disabled transmit section drops its copy and internal sync flags
    if (!state_next.ctrl.tx_en)
    begin
      state_next.copy_seen = 1'b0;
      state_next.tx_sync_int = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rd_data;
  assign tx_sync_pin_oe_o = state_reg.ctrl.src_sel;
  assign tx_sync_pin_o = state_reg.tx_sync_int ^ state_reg.ctrl.tx_pol;
  assign tx_data_pin_o = state_reg.tx_bit;
  assign tx_data_pin_oe_o = tx_busy;
  assign irq_o = |(state_reg.status & state_reg.mask);
endmodule
`default_nettype wire
